// ===== hw/eeprom_pkg.sv
// Shared constants for the data EEPROM write-control block.
// Assumes one system clock and an 8-bit special-register port from the CPU core.
package eeprom_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets in the special-register space
    localparam logic [7:0] CTRL_OFFSET = 8'h40;  // Control, bank 1 only
    localparam logic [7:0] ADDR_OFFSET = 8'h1E;  // Cell address, any bank
    localparam logic [7:0] DATA_OFFSET = 8'h1F;  // Data byte, any bank
    localparam logic [7:0] BANK_OFFSET = 8'h04;  // Bank select pointer
    localparam logic       CTRL_BANK   = 1'h1;   // Bank that exposes control

    ////////////////////////////////////////////////////////////////////////////
    // Control register field positions
    localparam int WR_EN_POS = 3;  // Write enable
    localparam int WR_POS    = 2;  // Write start
    localparam int RD_EN_POS = 1;  // Read enable
    localparam int RD_POS    = 0;  // Read start

    ////////////////////////////////////////////////////////////////////////////
    // Sizes and reset values
    localparam int         ADDR_W      = 7;      // Cell address width
    localparam int         DEPTH       = 128;    // Number of cells
    localparam logic [7:0] CELL_RESET  = 8'h00;  // Array content after reset
    localparam logic [7:0] REG_RESET   = 8'h00;  // Data and address reset value

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam logic [7:0] WRITE_TICKS = 8'h20;  // Timer clock edges per write
    localparam logic [2:0] READ_CYCLES = 3'h4;   // System clocks per read

    ////////////////////////////////////////////////////////////////////////////
    // Controller states
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_WRITING = 2'b01,
        ST_READING = 2'b10
    } ctrl_state_t;

endpackage

// ===== hw/eeprom_cell_timer.sv
// Programming timer for the EEPROM cell, counted on an asynchronous timer clock.
// Assumes tmr_clk_pin is free running and slower than half of clk_sys.
module eeprom_cell_timer (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_sync_b,
    // Asynchronous timer clock
    input  wire logic tmr_clk_pin,
    // Control
    input  wire logic start,
    output logic      busy,
    output logic      done
);

    ////////////////////////////////////////////////////////////////////////////
    // State record
    typedef struct packed {
        logic       meta;   // First synchroniser stage
        logic       sync;   // Second synchroniser stage
        logic       prev;   // Delayed copy for edge detection
        logic       busy;   // Programming in progress
        logic [7:0] cnt;    // Timer edges seen so far
        logic       done;   // One-cycle completion pulse
    } timer_state_t;

    timer_state_t r_reg;
    timer_state_t r_next;
    logic         tick;    // Rising edge of the timer clock

    ////////////////////////////////////////////////////////////////////////////
    // Next state: count timer edges while busy
    always_comb
    begin
        r_next      = r_reg;
        r_next.meta = tmr_clk_pin;
        r_next.sync = r_reg.meta;
        r_next.prev = r_reg.sync;
        r_next.done = 1'b0;
        tick        = r_reg.sync & ~r_reg.prev;
        if (start && !r_reg.busy)
        begin
            // Count starts at an unaligned point of the timer period; completion lands on a clk_sys cycle
            r_next.busy = 1'b1;
            r_next.cnt  = 8'h00;
        end
        else if (r_reg.busy && tick)
        begin
            if (r_reg.cnt == eeprom_pkg::WRITE_TICKS - 8'h01)
            begin
                // Whole count elapsed
                r_next.busy = 1'b0;
                r_next.done = 1'b1;
            end
            else
            begin
                r_next.cnt = r_reg.cnt + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk_sys or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    assign busy = r_reg.busy;
    assign done = r_reg.done;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_timer_holds_busy: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
        $rose(busy) |-> busy[*4])
        else $error("Programming ended too soon after start");

endmodule

// ===== hw/eeprom_write_ctrl.sv
// Data EEPROM controller: address, data, control and bank registers with cell array.
// Assumes the CPU core drives the special-register port on clk_sys.
module eeprom_write_ctrl (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    // Asynchronous programming timer clock
    input  wire logic       tmr_clk_pin,
    // Special-register port
    input  wire logic [7:0] mem_addr,
    input  wire logic       mem_wr,
    input  wire logic       mem_rd,
    input  wire logic [7:0] mem_wdata,
    output logic      [7:0] mem_rdata,
    // Interrupt handshake
    input  wire logic       eeprom_int_enable,
    input  wire logic       global_int_enable,
    input  wire logic       stack_full,
    input  wire logic       int_ack,
    output logic            int_request,
    output logic            eeprom_int_flag,
    // Bank pointer value seen by the core
    output logic            bank_select_pointer
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset synchroniser kept apart: it must act before the state record does
    logic rst_meta_b;   // First stage
    logic rst_sync_b;   // Released reset used everywhere

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end
        else
        begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State record
    typedef struct packed {
        eeprom_pkg::ctrl_state_t st;      // Controller state
        logic [6:0]              addr;    // Cell address
        logic [7:0]              data;    // Data byte
        logic                    bank;    // Bank select
        logic                    wr_en;   // Write enable
        logic                    wr;      // Write start / busy
        logic                    rd_en;   // Read enable
        logic                    rd;      // Read start / busy
        logic                    flag;    // Write-done interrupt flag
        logic [2:0]              rcnt;    // Read cycle counter
        logic [7:0]              rdata;   // Registered read answer
        logic [127:0][7:0]       cells;   // Cell array
    } ctrl_rec_t;

    ctrl_rec_t r_reg;
    ctrl_rec_t r_next;

    // Decoded accesses
    logic ctrl_hit;      // Address matches control, any bank
    logic ctrl_wr;       // Control write that lands
    logic data_wr;       // Data byte written by software
    logic read_done;     // Last read cycle
    logic start_write;   // Write launch pulse to timer
    logic tmr_busy;      // Timer still counting
    logic tmr_done;      // Programming finished

    assign ctrl_hit = (mem_addr == eeprom_pkg::CTRL_OFFSET);
    assign ctrl_wr  = mem_wr && ctrl_hit && (r_reg.bank == eeprom_pkg::CTRL_BANK);
    assign data_wr  = mem_wr && (mem_addr == eeprom_pkg::DATA_OFFSET);
    assign read_done = (r_reg.st == eeprom_pkg::ST_READING)
                    && (r_reg.rcnt == eeprom_pkg::READ_CYCLES - 3'h1);
    assign start_write = (r_reg.st == eeprom_pkg::ST_WRITING) && !tmr_busy && !tmr_done;

    ////////////////////////////////////////////////////////////////////////////
    // Programming timer on the asynchronous clock
    eeprom_cell_timer u_timer (
        .clk_sys     (clk_sys),
        .rst_sync_b  (rst_sync_b),
        .tmr_clk_pin (tmr_clk_pin),
        .start       (start_write),
        .busy        (tmr_busy),
        .done        (tmr_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state: register writes, operation sequencing, read answer
    always_comb
    begin
        r_next = r_reg;

        // Plain register writes
        if (mem_wr && mem_addr == eeprom_pkg::ADDR_OFFSET)
            r_next.addr = mem_wdata[6:0];
        if (data_wr)
            r_next.data = mem_wdata;
        if (mem_wr && mem_addr == eeprom_pkg::BANK_OFFSET)
            r_next.bank = mem_wdata[0];

        // Control write; start bits are set-only, hardware clears them
        if (ctrl_wr)
        begin
            r_next.wr_en = mem_wdata[eeprom_pkg::WR_EN_POS];
            r_next.rd_en = mem_wdata[eeprom_pkg::RD_EN_POS];
            if (r_reg.st == eeprom_pkg::ST_IDLE)
            begin
                // Start only counts if the enable was already set
                if (mem_wdata[eeprom_pkg::WR_POS] && r_reg.wr_en)
                begin
                    r_next.wr = 1'b1;
                    r_next.st = eeprom_pkg::ST_WRITING;
                end
                else if (mem_wdata[eeprom_pkg::RD_POS] && r_reg.rd_en)
                begin
                    r_next.rd   = 1'b1;
                    r_next.rcnt = 3'h0;
                    r_next.st   = eeprom_pkg::ST_READING;
                end
            end
        end

        // Read sequence: fixed count of system clocks
        if (r_reg.st == eeprom_pkg::ST_READING)
        begin
            if (read_done)
            begin
                r_next.rd   = 1'b0;
                r_next.data = r_reg.cells[r_reg.addr];
                r_next.st   = eeprom_pkg::ST_IDLE;
            end
            else
            begin
                r_next.rcnt = r_reg.rcnt + 3'h1;
            end
        end

        // Write completion from the timer
        if (r_reg.st == eeprom_pkg::ST_WRITING && tmr_done)
        begin
            r_next.cells[r_reg.addr] = r_reg.data;
            r_next.wr = 1'b0;
            r_next.st = eeprom_pkg::ST_IDLE;
        end

        // Flag: a completion in the acknowledge cycle wins over the clear
        if (int_ack)
            r_next.flag = 1'b0;
        if (r_reg.st == eeprom_pkg::ST_WRITING && tmr_done)
            r_next.flag = 1'b1;

        // Registered read answer; unmapped and hidden addresses read zero
        r_next.rdata = 8'h00;
        if (mem_rd)
        begin
            case (mem_addr)
                eeprom_pkg::ADDR_OFFSET: r_next.rdata = {1'b0, r_reg.addr};
                eeprom_pkg::DATA_OFFSET: r_next.rdata = r_reg.data;
                eeprom_pkg::BANK_OFFSET: r_next.rdata = {7'h00, r_reg.bank};
                eeprom_pkg::CTRL_OFFSET:
                begin
                    if (r_reg.bank == eeprom_pkg::CTRL_BANK)
                        r_next.rdata = {4'h0, r_reg.wr_en, r_reg.wr, r_reg.rd_en, r_reg.rd};
                end
                default: r_next.rdata = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; reset clears enables, starts and the bank pointer
    always_ff @(posedge clk_sys or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            r_reg       <= '0;
            r_reg.st    <= eeprom_pkg::ST_IDLE;
            r_reg.data  <= eeprom_pkg::REG_RESET;
            r_reg.cells <= {eeprom_pkg::DEPTH{eeprom_pkg::CELL_RESET}};
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign mem_rdata           = r_reg.rdata;
    assign eeprom_int_flag     = r_reg.flag;
    assign bank_select_pointer = r_reg.bank;
    // Vector request only when every gate is open
    assign int_request = r_reg.flag && eeprom_int_enable
                      && global_int_enable && !stack_full;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_wr_needs_enable: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
        $rose(r_reg.wr) |-> $past(r_reg.wr_en))
        else $error("Write started without write enable");

    a_wr_self_clear: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
        (r_reg.wr && tmr_done) |=> !r_reg.wr)
        else $error("Write start not cleared at completion");

    a_flag_on_done: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
        (r_reg.st == eeprom_pkg::ST_WRITING && tmr_done) |=> eeprom_int_flag)
        else $error("Flag not set at write end");

    a_int_gated: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
        int_request |-> (eeprom_int_flag && eeprom_int_enable && global_int_enable && !stack_full))
        else $error("Interrupt requested with a gate closed");

    a_ack_clears: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
        (int_ack && !tmr_done) |=> !eeprom_int_flag)
        else $error("Flag survived interrupt service");

    a_rd_needs_enable: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
        $rose(r_reg.rd) |-> $past(r_reg.rd_en))
        else $error("Read started without read enable");

    a_rd_duration: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
        $rose(r_reg.rd) |-> r_reg.rd[*4] ##1 (!r_reg.rd && r_reg.data == $past(r_reg.cells[r_reg.addr])))
        else $error("Read start length or fetched byte wrong");

    a_data_hold: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
        $changed(r_reg.data) |-> ($past(data_wr) || $past(read_done)))
        else $error("Data byte changed without an operation");

    a_addr_bit7: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
        (mem_rd && mem_addr == eeprom_pkg::ADDR_OFFSET) |=> !mem_rdata[7])
        else $error("Address bit seven read as one");

    a_ctrl_bank0: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
        (mem_wr && ctrl_hit && !r_reg.bank) |=> (r_reg.wr_en == $past(r_reg.wr_en)))
        else $error("Control written while bank zero selected");

endmodule

// ===== bench/tb_top.sv
// Self-checking bench for the data EEPROM write-control block.
// Assumes the design files and package are compiled first; drives every port itself.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    ////////////////////////////////////////////////////////////////////////////
    // Stimulus and observed signals
    logic       clk_sys;              // System clock, 250 MHz
    logic       rst_b;                // Active-low reset
    logic       tmr_clk_pin;          // Free running programming timer clock
    logic [7:0] mem_addr;             // Register address
    logic       mem_wr;               // Write strobe
    logic       mem_rd;               // Read strobe
    logic [7:0] mem_wdata;            // Write data
    logic [7:0] mem_rdata;            // Read answer
    logic       eeprom_int_enable;    // Interrupt enable
    logic       global_int_enable;    // Global interrupt enable
    logic       stack_full;           // Return stack full
    logic       int_ack;              // Interrupt serviced pulse
    logic       int_request;          // Interrupt request out
    logic       eeprom_int_flag;      // Write-done flag out
    logic       bank_select_pointer;  // Bank bit out
    int         n_mismatch;           // Mismatches seen
    int         compares;             // Comparisons made
    logic [7:0] rv;                   // Last read value

    ////////////////////////////////////////////////////////////////////////////
    // Clocks; the timer half period is chosen so its edges meet clk_sys edges only once every 222 ns
    initial clk_sys = 1'b0;
    always #2 clk_sys = ~clk_sys;
    initial tmr_clk_pin = 1'b0;
    always #11.1 tmr_clk_pin = ~tmr_clk_pin;

    ////////////////////////////////////////////////////////////////////////////
    // Device under test
    eeprom_write_ctrl uut (
        .clk_sys             (clk_sys),
        .rst_b               (rst_b),
        .tmr_clk_pin         (tmr_clk_pin),
        .mem_addr            (mem_addr),
        .mem_wr              (mem_wr),
        .mem_rd              (mem_rd),
        .mem_wdata           (mem_wdata),
        .mem_rdata           (mem_rdata),
        .eeprom_int_enable   (eeprom_int_enable),
        .global_int_enable   (global_int_enable),
        .stack_full          (stack_full),
        .int_ack             (int_ack),
        .int_request         (int_request),
        .eeprom_int_flag     (eeprom_int_flag),
        .bank_select_pointer (bank_select_pointer)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks; all of them are entered and left just after a rising edge
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One write, then a free edge so the strobe is never reassigned in one step
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        mem_addr  <= a;
        mem_wdata <= d;
        mem_wr    <= 1'b1;
        @(posedge clk_sys);
        mem_wr    <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Two writes to one place on consecutive edges
    task automatic wr2(input logic [7:0] a, input logic [7:0] d1, input logic [7:0] d2);
        mem_addr  <= a;
        mem_wdata <= d1;
        mem_wr    <= 1'b1;
        @(posedge clk_sys);
        mem_wdata <= d2;
        @(posedge clk_sys);
        mem_wr    <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Read; the answer stands for the cycle after the taking edge only
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        mem_addr <= a;
        mem_rd   <= 1'b1;
        @(posedge clk_sys);
        mem_rd   <= 1'b0;
        #1;
        d = mem_rdata;
        @(posedge clk_sys);
    endtask

    // Poll a control bit until it clears, bounded; returns polls used
    task automatic poll_clear(input int pos, input int lim, output int n);
        n = 0;
        rd_reg(eeprom_pkg::CTRL_OFFSET, rv);
        while (rv[pos] !== 1'b0 && n < lim)
        begin
            n++;
            rd_reg(eeprom_pkg::CTRL_OFFSET, rv);
        end
        chk("start bit cleared", 8'h00, {7'h00, rv[pos]});
    endtask

    task automatic end_sim;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        chk("bank", 8'h00, {7'h00, bank_select_pointer});
        chk("flag", 8'h00, {7'h00, eeprom_int_flag});
        rd_reg(eeprom_pkg::ADDR_OFFSET, rv);
        chk("addr reset", 8'h00, rv);
        wr_reg(eeprom_pkg::CTRL_OFFSET, 8'h08); // Bank 0: must be ignored
        wr_reg(eeprom_pkg::BANK_OFFSET, 8'h01);
        chk("bank set", 8'h01, {7'h00, bank_select_pointer});
        rd_reg(eeprom_pkg::CTRL_OFFSET, rv);
        chk("ctrl gated", 8'h00, rv);
        rd_reg(8'h55, rv);
        chk("unmapped", 8'h00, rv);
        $display("test reset done");
    endtask

    task automatic t_wr_refuse;
        wr_reg(eeprom_pkg::CTRL_OFFSET, 8'h04);
        rd_reg(eeprom_pkg::CTRL_OFFSET, rv);
        chk("start refused", 8'h00, rv);
        wr_reg(eeprom_pkg::CTRL_OFFSET, 8'hF8);
        rd_reg(eeprom_pkg::CTRL_OFFSET, rv);
        chk("ctrl fields", 8'h08, rv);
        repeat (250) @(posedge clk_sys);
        chk("no write flag", 8'h00, {7'h00, eeprom_int_flag});
        $display("test write refusal done");
    endtask

    task automatic t_write;
        int n;
        wr_reg(eeprom_pkg::ADDR_OFFSET, 8'h85);
        wr_reg(eeprom_pkg::DATA_OFFSET, 8'h5A);
        rd_reg(eeprom_pkg::ADDR_OFFSET, rv);
        chk("addr bit7", 8'h05, rv);
        global_int_enable <= 1'b0;
        wr2(eeprom_pkg::CTRL_OFFSET, 8'h08, 8'h0C);
        global_int_enable <= 1'b1;
        rd_reg(eeprom_pkg::CTRL_OFFSET, rv);
        chk("write busy", 8'h0C, rv);
        chk("flag early", 8'h00, {7'h00, eeprom_int_flag});
        poll_clear(eeprom_pkg::WR_POS, 600, n);
        chk("long write", 8'h01, {7'h00, n >= 80});
        chk("flag at end", 8'h01, {7'h00, eeprom_int_flag});
        $display("test write done");
    endtask

    task automatic t_irq;
        logic [2:0] c;
        for (int i = 0; i < 8; i++)
        begin
            c = 3'(i);
            eeprom_int_enable <= c[0];
            global_int_enable <= c[1];
            stack_full        <= c[2];
            @(posedge clk_sys);
            #1;
            chk("int request", {7'h00, c[0] & c[1] & ~c[2]}, {7'h00, int_request});
            @(posedge clk_sys);
        end
        int_ack <= 1'b1;
        @(posedge clk_sys);
        int_ack <= 1'b0;
        @(posedge clk_sys);
        chk("flag cleared", 8'h00, {7'h00, eeprom_int_flag});
        $display("test interrupt done");
    endtask

    task automatic t_read;
        int n;
        wr_reg(eeprom_pkg::ADDR_OFFSET, 8'h05);
        wr_reg(eeprom_pkg::DATA_OFFSET, 8'hA7);
        wr_reg(eeprom_pkg::CTRL_OFFSET, 8'h00);
        wr_reg(eeprom_pkg::CTRL_OFFSET, 8'h01);
        rd_reg(eeprom_pkg::CTRL_OFFSET, rv);
        chk("read refused", 8'h00, rv);
        rd_reg(eeprom_pkg::DATA_OFFSET, rv);
        chk("data kept", 8'hA7, rv);
        wr2(eeprom_pkg::CTRL_OFFSET, 8'h02, 8'h03);
        poll_clear(eeprom_pkg::RD_POS, 20, n);
        rd_reg(eeprom_pkg::DATA_OFFSET, rv);
        chk("read data", 8'h5A, rv);
        repeat (20) @(posedge clk_sys);
        rd_reg(eeprom_pkg::DATA_OFFSET, rv);
        chk("data held", 8'h5A, rv);
        wr_reg(eeprom_pkg::BANK_OFFSET, 8'h00);
        rd_reg(eeprom_pkg::CTRL_OFFSET, rv);
        chk("ctrl hidden", 8'h00, rv);
        $display("test read done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial
    begin
        n_mismatch = 0;
        compares = 0;
        rst_b = 1'b0;
        mem_addr = 8'h00;
        mem_wr = 1'b0;
        mem_rd = 1'b0;
        mem_wdata = 8'h00;
        eeprom_int_enable = 1'b0;
        global_int_enable = 1'b0;
        stack_full = 1'b0;
        int_ack = 1'b0;
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_reset();
        t_wr_refuse();
        t_write();
        t_irq();
        t_read();
        end_sim();
    end

    // Tests need well under a thousand cycles; this span leaves ample margin
    initial
    begin
        #60000;
        n_mismatch++;
        $display("BAD watchdog expected finish seen hang");
        end_sim();
    end
endmodule
